// [dmac_top.sv]
////////////////////////////////////////////////////////////////////////////////
// Operation
// - Multiply two 16-bit half-word operands into the selected accumulator.
// - Load, add or subtract the product, always saturating the accumulator.
// - Unit zero works only on accumulator zero, unit one on accumulator one.
// - Default: signed 1.15 fractions, product shifted left, saturate to 9.31.
// - Fractional most-negative squared gives largest positive before accumulation.
// - Unsigned fraction: 0.16 operands, no shift, saturate to 8.32 unsigned.
// - Unsigned integers share that option: saturate between zero and all ones.
// - Signed integer: no shift, sign-extend, saturate to signed 40-bit range.
// - Bit-31 saturation: default fractions, accumulator limited to 1.31 range.
// - Mixed mode on unit one only: first source signed, second unsigned.
// - Mixed with bit-31 saturation: both units saturate at 32 bits.
// - Accumulator-zero overflow flag follows saturation of its result.
// - Accumulator-one overflow flag follows saturation of its result.
// - Sticky flags set with their overflow flag, otherwise hold.
// - No other status flag is touched by an operation.
module dmac_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Unit zero request
	input wire dmac_pkg::dmac_op_t opZero,
	input wire logic [15:0] srcZeroA,
	input wire logic [15:0] srcZeroB,
	// Unit one request
	input wire dmac_pkg::dmac_op_t opOne,
	input wire logic [15:0] srcOneA,
	input wire logic [15:0] srcOneB,
	input wire logic mixedOne,
	// Shared option
	input wire dmac_pkg::dmac_mode_t mode,
	// Accumulators
	output logic [39:0] accumulatorZero,
	output logic [39:0] accumulatorOne,
	// Status flags
	output logic accZeroOverflowFlag,
	output logic accZeroStickyOverflow,
	output logic accOneOverflowFlag,
	output logic accOneStickyOverflow
);

	logic [39:0] resZero;
	logic [39:0] resOne;
	logic satZero;
	logic satOne;
	logic [39:0] next_accumulatorZero;
	logic [39:0] next_accumulatorOne;
	logic next_accZeroOverflowFlag;
	logic next_accZeroStickyOverflow;
	logic next_accOneOverflowFlag;
	logic next_accOneStickyOverflow;
	logic mixedOk;

	////////////////////////////////////////////////////////////////////////////
	// Lanes; mixed is hard-wired off on unit zero
	dmac_unit u_zero (
		.srcA(srcZeroA),
		.srcB(srcZeroB),
		.op(opZero),
		.mode(mode),
		.mixed(1'b0),
		.accIn(accumulatorZero),
		.accOut(resZero),
		.saturated(satZero)
	);

	// Mixed only honoured in default (fraction) or bit-31 mode, or signed integer
	assign mixedOk = mixedOne && (mode != dmac_pkg::DMAC_MODE_UNSIGNED);

	dmac_unit u_one (
		.srcA(srcOneA),
		.srcB(srcOneB),
		.op(opOne),
		.mode(mode),
		.mixed(mixedOk),
		.accIn(accumulatorOne),
		.accOut(resOne),
		.saturated(satOne)
	);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_accumulatorZero = accumulatorZero;
		next_accumulatorOne = accumulatorOne;
		next_accZeroOverflowFlag = accZeroOverflowFlag;
		next_accZeroStickyOverflow = accZeroStickyOverflow;
		next_accOneOverflowFlag = accOneOverflowFlag;
		next_accOneStickyOverflow = accOneStickyOverflow;
		if (opZero != dmac_pkg::DMAC_OP_NONE) begin
			next_accumulatorZero = resZero;
			next_accZeroOverflowFlag = satZero;
			next_accZeroStickyOverflow = accZeroStickyOverflow | satZero;
		end
		// Separate branch so the lanes never interfere
		if (opOne != dmac_pkg::DMAC_OP_NONE) begin
			next_accumulatorOne = resOne;
			next_accOneOverflowFlag = satOne;
			next_accOneStickyOverflow = accOneStickyOverflow | satOne;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			accumulatorZero <= dmac_pkg::ACC_RESET;
			accumulatorOne <= dmac_pkg::ACC_RESET;
			accZeroOverflowFlag <= 1'b0;
			accZeroStickyOverflow <= 1'b0;
			accOneOverflowFlag <= 1'b0;
			accOneStickyOverflow <= 1'b0;
		end else begin
			accumulatorZero <= next_accumulatorZero;
			accumulatorOne <= next_accumulatorOne;
			accZeroOverflowFlag <= next_accZeroOverflowFlag;
			accZeroStickyOverflow <= next_accZeroStickyOverflow;
			accOneOverflowFlag <= next_accOneOverflowFlag;
			accOneStickyOverflow <= next_accOneStickyOverflow;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_load_zero_value: assert property (@(posedge clk) disable iff (rst)
		opZero != dmac_pkg::DMAC_OP_NONE |=> accumulatorZero == $past(resZero))
		else $error("Accumulator zero did not take its result");
	a_flag_zero_track: assert property (@(posedge clk) disable iff (rst)
		opZero != dmac_pkg::DMAC_OP_NONE |=> accZeroOverflowFlag == $past(satZero))
		else $error("Accumulator zero overflow flag wrong");
	a_flag_one_track: assert property (@(posedge clk) disable iff (rst)
		opOne != dmac_pkg::DMAC_OP_NONE |=> accOneOverflowFlag == $past(satOne))
		else $error("Accumulator one overflow flag wrong");
	a_sticky_zero_hold: assert property (@(posedge clk) disable iff (rst)
		accZeroStickyOverflow && !$rose(accZeroStickyOverflow) |=> accZeroStickyOverflow)
		else $error("Sticky zero dropped");
	a_sticky_one_set: assert property (@(posedge clk) disable iff (rst)
		accOneOverflowFlag |-> accOneStickyOverflow)
		else $error("Sticky one missing");
	a_idle_one_hold: assert property (@(posedge clk) disable iff (rst)
		opOne == dmac_pkg::DMAC_OP_NONE |=> $stable(accumulatorOne) && $stable(accOneOverflowFlag))
		else $error("Accumulator one changed while idle");
	a_sat31_range: assert property (@(posedge clk) disable iff (rst)
		opZero != dmac_pkg::DMAC_OP_NONE && mode == dmac_pkg::DMAC_MODE_SAT31
		|=> accumulatorZero[39:31] == {9{accumulatorZero[31]}})
		else $error("Bit-31 saturation exceeded");
	a_minsq_frac: assert property (@(posedge clk) disable iff (rst)
		opZero == dmac_pkg::DMAC_OP_LOAD && mode == dmac_pkg::DMAC_MODE_DEFAULT
		&& srcZeroA == dmac_pkg::FRAC_MOST_NEG && srcZeroB == dmac_pkg::FRAC_MOST_NEG
		|=> accumulatorZero == 40'h00_7FFF_FFFF && !accZeroOverflowFlag)
		else $error("Most negative square wrong");
	a_unsigned_int: assert property (@(posedge clk) disable iff (rst)
		opOne == dmac_pkg::DMAC_OP_LOAD && mode == dmac_pkg::DMAC_MODE_UNSIGNED
		|=> accumulatorOne == {8'h00, 32'($past(srcOneA)) * 32'($past(srcOneB))})
		else $error("Unsigned product wrong");

	a_load_one_value: assert property (@(posedge clk) disable iff (rst)
		opOne != dmac_pkg::DMAC_OP_NONE |=> accumulatorOne == $past(resOne))
		else $error("Accumulator one did not take its result");

	a_sticky_zero_set: assert property (@(posedge clk) disable iff (rst)
		accZeroOverflowFlag |-> accZeroStickyOverflow)
		else $error("Sticky zero missing");

	// Only reset may drop a sticky flag
	a_sticky_one_hold: assert property (@(posedge clk) disable iff (rst)
		accOneStickyOverflow |=> accOneStickyOverflow)
		else $error("Sticky one dropped");

	a_idle_zero_hold: assert property (@(posedge clk) disable iff (rst)
		opZero == dmac_pkg::DMAC_OP_NONE
		|=> $stable(accumulatorZero) && $stable(accZeroOverflowFlag))
		else $error("Accumulator zero changed while idle");

	a_sat31_one_range: assert property (@(posedge clk) disable iff (rst)
		opOne != dmac_pkg::DMAC_OP_NONE && mode == dmac_pkg::DMAC_MODE_SAT31
		|=> accumulatorOne[39:31] == {9{accumulatorOne[31]}})
		else $error("Bit-31 saturation exceeded on unit one");

	a_ufrac_load_zero: assert property (@(posedge clk) disable iff (rst)
		opZero == dmac_pkg::DMAC_OP_LOAD && mode == dmac_pkg::DMAC_MODE_UNSIGNED
		|=> accumulatorZero == {8'h00, 32'($past(srcZeroA)) * 32'($past(srcZeroB))})
		else $error("Unsigned fraction product wrong");

	// Integer products take no shift correction
	a_sint_load_one: assert property (@(posedge clk) disable iff (rst)
		opOne == dmac_pkg::DMAC_OP_LOAD && mode == dmac_pkg::DMAC_MODE_SIGNED_INT && !mixedOne
		|=> $signed(accumulatorOne) == $signed($past(srcOneA)) * $signed($past(srcOneB)))
		else $error("Signed integer product wrong");

	// Second source is read unsigned, still without shift
	a_mixed_load_one: assert property (@(posedge clk) disable iff (rst)
		opOne == dmac_pkg::DMAC_OP_LOAD && mode == dmac_pkg::DMAC_MODE_DEFAULT && mixedOne
		|=> $signed(accumulatorOne) == $signed($past(srcOneA)) * $signed({1'b0, $past(srcOneB)}))
		else $error("Mixed product wrong");

	a_frac_load_zero: assert property (@(posedge clk) disable iff (rst)
		opZero == dmac_pkg::DMAC_OP_LOAD && mode == dmac_pkg::DMAC_MODE_DEFAULT
		&& !(srcZeroA == dmac_pkg::FRAC_MOST_NEG && srcZeroB == dmac_pkg::FRAC_MOST_NEG)
		|=> $signed(accumulatorZero) == $signed({$past(srcZeroA), 1'b0}) * $signed($past(srcZeroB)))
		else $error("Fraction product wrong");

	// Unsigned accumulator may not wrap below zero
	a_usub_floor_one: assert property (@(posedge clk) disable iff (rst)
		opOne == dmac_pkg::DMAC_OP_SUB && mode == dmac_pkg::DMAC_MODE_UNSIGNED
		&& accumulatorOne < {8'h00, 32'(srcOneA) * 32'(srcOneB)}
		|=> accumulatorOne == dmac_pkg::SAT_U40_MIN[39:0] && accOneOverflowFlag)
		else $error("Unsigned floor not held");

	a_sat31_clamp_zero: assert property (@(posedge clk) disable iff (rst)
		opZero != dmac_pkg::DMAC_OP_NONE && mode == dmac_pkg::DMAC_MODE_SAT31 && satZero
		|=> accumulatorZero == dmac_pkg::SAT_S32_MAX[39:0]
		|| accumulatorZero == dmac_pkg::SAT_S32_MIN[39:0])
		else $error("Bit-31 clamp value wrong");

	a_s40_clamp_zero: assert property (@(posedge clk) disable iff (rst)
		opZero != dmac_pkg::DMAC_OP_NONE && mode == dmac_pkg::DMAC_MODE_DEFAULT && satZero
		|=> accumulatorZero == dmac_pkg::SAT_S40_MAX[39:0]
		|| accumulatorZero == dmac_pkg::SAT_S40_MIN[39:0])
		else $error("Fraction clamp value wrong");

	// Mixed request must not reach unit zero
	a_zero_ignores_mixed: assert property (@(posedge clk) disable iff (rst)
		opZero == dmac_pkg::DMAC_OP_LOAD && mode == dmac_pkg::DMAC_MODE_SAT31 && mixedOne
		&& srcZeroA == dmac_pkg::FRAC_MOST_NEG && srcZeroB == dmac_pkg::FRAC_MOST_NEG
		|=> accumulatorZero == 40'(dmac_pkg::FRAC_MAX_PROD))
		else $error("Unit zero took mixed mode");

endmodule

// [dmac_pkg.sv]
package dmac_pkg;

	// Accumulator and operand geometry
	localparam int ACC_W = 40;
	localparam int OPD_W = 16;
	localparam int PROD_W = 32;
	localparam int SUM_W = 42;

	// Operation select
	typedef enum logic [1:0] {
		DMAC_OP_NONE = 2'b00,
		DMAC_OP_LOAD = 2'b01,
		DMAC_OP_ADD = 2'b10,
		DMAC_OP_SUB = 2'b11
	} dmac_op_t;

	// Option select
	typedef enum logic [1:0] {
		DMAC_MODE_DEFAULT = 2'b00,
		DMAC_MODE_UNSIGNED = 2'b01,
		DMAC_MODE_SIGNED_INT = 2'b10,
		DMAC_MODE_SAT31 = 2'b11
	} dmac_mode_t;

	// Saturation bounds, as 42-bit signed values
	localparam logic [41:0] SAT_S40_MAX = 42'h07F_FFFF_FFFF;
	localparam logic [41:0] SAT_S40_MIN = 42'h380_0000_0000;
	localparam logic [41:0] SAT_U40_MAX = 42'h0FF_FFFF_FFFF;
	localparam logic [41:0] SAT_U40_MIN = 42'h000_0000_0000;
	localparam logic [41:0] SAT_S32_MAX = 42'h000_7FFF_FFFF;
	localparam logic [41:0] SAT_S32_MIN = 42'h3FF_8000_0000;

	// Special fractional case
	localparam logic [15:0] FRAC_MOST_NEG = 16'h8000;
	localparam logic [31:0] FRAC_MAX_PROD = 32'h7FFF_FFFF;

	// Reset value
	localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;

endpackage

// [dmac_unit.sv]
// One multiply-accumulate lane: product forming, accumulation, saturation
module dmac_unit (
	// Operands and controls
	input wire logic [15:0] srcA,
	input wire logic [15:0] srcB,
	input wire dmac_pkg::dmac_op_t op,
	input wire dmac_pkg::dmac_mode_t mode,
	input wire logic mixed,
	input wire logic [39:0] accIn,
	// Results
	output logic [39:0] accOut,
	output logic saturated
);

	logic signed [16:0] opA;
	logic signed [16:0] opB;
	logic signed [33:0] rawProd;
	logic signed [41:0] prodExt;
	logic signed [41:0] accExt;
	logic signed [41:0] sum;
	logic signed [41:0] hiBound;
	logic signed [41:0] loBound;
	logic isUnsigned;
	logic isFrac;

	always_comb begin
		isUnsigned = (mode == dmac_pkg::DMAC_MODE_UNSIGNED);
		isFrac = (mode == dmac_pkg::DMAC_MODE_DEFAULT) || (mode == dmac_pkg::DMAC_MODE_SAT31);
		// Extend to 17 bits so one signed multiplier serves every format
		opA = isUnsigned ? {1'b0, srcA} : {srcA[15], srcA};
		opB = (isUnsigned || mixed) ? {1'b0, srcB} : {srcB[15], srcB};
		rawProd = opA * opB;
		prodExt = 42'(rawProd);
		if (isFrac && !mixed) begin
			// Left-shift correction; the only overflow case is -1 * -1
			if (srcA == dmac_pkg::FRAC_MOST_NEG && srcB == dmac_pkg::FRAC_MOST_NEG) begin
				prodExt = 42'(dmac_pkg::FRAC_MAX_PROD);
			end else begin
				prodExt = 42'(rawProd <<< 1);
			end
		end
		// Accumulator value zero- or sign-extended to 42 bits by the signedness of the current format
		accExt = isUnsigned ? {2'b00, accIn} : {{2{accIn[39]}}, accIn};
		case (op)
			dmac_pkg::DMAC_OP_ADD: sum = accExt + prodExt;
			dmac_pkg::DMAC_OP_SUB: sum = accExt - prodExt;
			default: sum = prodExt;
		endcase
		case (mode)
			dmac_pkg::DMAC_MODE_UNSIGNED: begin
				hiBound = dmac_pkg::SAT_U40_MAX;
				loBound = dmac_pkg::SAT_U40_MIN;
			end
			dmac_pkg::DMAC_MODE_SAT31: begin
				hiBound = dmac_pkg::SAT_S32_MAX;
				loBound = dmac_pkg::SAT_S32_MIN;
			end
			default: begin
				hiBound = dmac_pkg::SAT_S40_MAX;
				loBound = dmac_pkg::SAT_S40_MIN;
			end
		endcase
		// Judged on the full 42-bit result before truncation
		if (sum > hiBound) begin
			accOut = hiBound[39:0];
			saturated = 1'b1;
		end else if (sum < loBound) begin
			accOut = loBound[39:0];
			saturated = 1'b1;
		end else begin
			accOut = sum[39:0];
			saturated = 1'b0;
		end
	end

endmodule

// [dmac_seq_model.sv]
// Sequencer side: presents one request per clock from the register file halves
module dmac_seq_model (
	// Clock
	input wire logic clk,
	// Requests
	output dmac_pkg::dmac_op_t opZero,
	output logic [15:0] srcZeroA,
	output logic [15:0] srcZeroB,
	output dmac_pkg::dmac_op_t opOne,
	output logic [15:0] srcOneA,
	output logic [15:0] srcOneB,
	output logic mixedOne,
	output dmac_pkg::dmac_mode_t mode
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		opZero = dmac_pkg::DMAC_OP_NONE;
		opOne = dmac_pkg::DMAC_OP_NONE;
		{srcZeroA, srcZeroB, srcOneA, srcOneB} = 64'h0;
		mixedOne = 1'b0;
		mode = dmac_pkg::DMAC_MODE_DEFAULT;
	end
	// Drives just after an edge so the next edge takes it
	task automatic issue(input dmac_pkg::dmac_op_t o0, input logic [15:0] a0, b0,
		input dmac_pkg::dmac_op_t o1, input logic [15:0] a1, b1,
		input dmac_pkg::dmac_mode_t md, input logic mx);
		@(posedge clk);
		#1;
		opZero = o0;
		srcZeroA = a0;
		srcZeroB = b0;
		opOne = o1;
		srcOneA = a1;
		srcOneB = b1;
		mode = md;
		mixedOne = mx;
	endtask
	// Lets the last request be taken, then idles both units
	task automatic idle();
		@(posedge clk);
		#1;
		opZero = dmac_pkg::DMAC_OP_NONE;
		opOne = dmac_pkg::DMAC_OP_NONE;
	endtask
endmodule

// [testbench.sv]
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam dmac_pkg::dmac_op_t NO = dmac_pkg::DMAC_OP_NONE;
	localparam dmac_pkg::dmac_op_t LD = dmac_pkg::DMAC_OP_LOAD;
	localparam dmac_pkg::dmac_op_t AD = dmac_pkg::DMAC_OP_ADD;
	localparam dmac_pkg::dmac_op_t SB = dmac_pkg::DMAC_OP_SUB;
	localparam dmac_pkg::dmac_mode_t DF = dmac_pkg::DMAC_MODE_DEFAULT;
	localparam dmac_pkg::dmac_mode_t US = dmac_pkg::DMAC_MODE_UNSIGNED;
	localparam dmac_pkg::dmac_mode_t SI = dmac_pkg::DMAC_MODE_SIGNED_INT;
	localparam dmac_pkg::dmac_mode_t S31 = dmac_pkg::DMAC_MODE_SAT31;
	logic clk;
	logic rst;
	dmac_pkg::dmac_op_t opZero, opOne;
	dmac_pkg::dmac_mode_t mode;
	logic [15:0] srcZeroA, srcZeroB, srcOneA, srcOneB;
	logic mixedOne;
	logic [39:0] accZ, accO;
	logic fZ, sZ, fO, sO;
	logic [3:0] flags;
	int mismatches;
	int samples_checked;
	assign flags = {fZ, sZ, fO, sO};
	dmac_seq_model m (.clk(clk), .opZero(opZero), .srcZeroA(srcZeroA), .srcZeroB(srcZeroB),
		.opOne(opOne), .srcOneA(srcOneA), .srcOneB(srcOneB), .mixedOne(mixedOne), .mode(mode));
	dmac_top uut (.clk(clk), .rst(rst), .opZero(opZero), .srcZeroA(srcZeroA),
		.srcZeroB(srcZeroB), .opOne(opOne), .srcOneA(srcOneA), .srcOneB(srcOneB),
		.mixedOne(mixedOne), .mode(mode), .accumulatorZero(accZ), .accumulatorOne(accO),
		.accZeroOverflowFlag(fZ), .accZeroStickyOverflow(sZ), .accOneOverflowFlag(fO),
		.accOneStickyOverflow(sO));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checked %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Whole sequence is under 400 cycles
	initial begin
		#20000;
		mismatches++;
		final_report();
	end
	initial begin
		rst = 1'b1;
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		chk({accZ, accO[3:0], flags}, 48'h0000_0000_0000);
		m.issue(LD, 16'h4000, 16'h4000, NO, 16'h0000, 16'h0000, DF, 1'b0);
		m.idle();
		chk(accZ, 40'h00_2000_0000);
		chk(accO, 40'h00_0000_0000);
		// Unit one mixed beside the most negative square on unit zero
		m.issue(LD, 16'h8000, 16'h8000, LD, 16'hFFFF, 16'hFFFF, DF, 1'b1);
		m.idle();
		chk(accZ, 40'h00_7FFF_FFFF);
		chk(accO, 40'hFF_FFFF_0001);
		chk(40'(flags), 40'h00_0000_0000);
		m.issue(AD, 16'h8000, 16'h8000, NO, 16'h0000, 16'h0000, DF, 1'b0);
		m.issue(SB, 16'h4000, 16'h4000, NO, 16'h0000, 16'h0000, DF, 1'b0);
		m.idle();
		chk(accZ, 40'h00_DFFF_FFFE);
		chk(accO, 40'hFF_FFFF_0001);
		// Enough adds to cross the 9.31 ceiling
		repeat (257) m.issue(AD, 16'h8000, 16'h8000, NO, 16'h0000, 16'h0000, DF, 1'b0);
		m.idle();
		chk(accZ, 40'h7F_FFFF_FFFF);
		chk(40'(flags), 40'h00_0000_000C);
		m.issue(LD, 16'h0001, 16'h0001, LD, 16'h8000, 16'h7FFF, SI, 1'b0);
		m.idle();
		chk(accO, 40'hFF_C000_8000);
		chk(40'(flags), 40'h00_0000_0004);
		m.issue(LD, 16'h8000, 16'h8000, LD, 16'h0001, 16'h0001, US, 1'b1);
		m.idle();
		chk(accZ, 40'h00_4000_0000);
		m.issue(NO, 16'h0000, 16'h0000, SB, 16'h0002, 16'h0001, US, 1'b0);
		m.idle();
		chk(accO, 40'h00_0000_0000);
		chk(40'(flags), 40'h00_0000_0007);
		m.issue(LD, 16'h8000, 16'h8000, LD, 16'h7FFF, 16'hFFFF, S31, 1'b1);
		m.issue(AD, 16'h4000, 16'h4000, AD, 16'h7FFF, 16'hFFFF, S31, 1'b1);
		m.idle();
		chk({accZ, accO}, 80'h00_7FFF_FFFF_00_7FFF_FFFF);
		chk(40'(flags), 40'h00_0000_000F);
		repeat (3) m.issue(SB, 16'h8000, 16'h8000, NO, 16'h0000, 16'h0000, S31, 1'b0);
		m.idle();
		chk(accZ, 40'hFF_8000_0000);
		chk(40'(flags), 40'h00_0000_000F);
		final_report();
	end
endmodule
